/* inc/mmd_regs.svh */
// Register indices, byte addresses, field positions, reset values and decode bases for the memory map decoder.
// Assumes the includer wants plain `define constants; types live in mmd_pkg.
`ifndef MMD_REGS_SVH
`define MMD_REGS_SVH

`define MMD_IDX_ADDR_CTRL 12'h09D
`define MMD_IDX_MEM_CTRL 12'h0C6
`define MMD_IDX_MEM_CTRL_EXT 12'h0C7
`define MMD_IDX_STATUS 12'h0C8
`define MMD_ADDR_ADDR_CTRL 12'h274
`define MMD_ADDR_MEM_CTRL 12'h318
`define MMD_ADDR_MEM_CTRL_EXT 12'h31C
`define MMD_ADDR_STATUS 12'h320

`define MMD_ADDRESS_CONTROL_STACK_EXT_BIT 2
`define MMD_ADDRESS_CONTROL_ROM_REMAP_BIT 5
`define MMD_MEMORY_CONTROL_CAN_REMAP_BIT 3
`define MMD_MEMORY_CONTROL_DMS_LSB 6
`define MMD_MCONX_ROM_BYPASS_BIT 0
`define MMD_MCONX_PRAM_SEL_BIT 6
`define MMD_MCONX_IRAM_DIS_BIT 7

`define MMD_ADDRESS_CONTROL_RESET 8'h00
`define MMD_MEMORY_CONTROL_RESET 8'h00
`define MMD_MCONX_RESET 1'b0

`define MMD_ROM_HI_TAG 9'h1FF
`define MMD_ROM_LO_TAG_LOW 9'h000
`define MMD_ROM_LO_TAG_HIGH 9'h1FE
`define MMD_CAN_TAG_LOW 16'h00DB
`define MMD_CAN_TAG_HIGH 16'hFFDB
`define MMD_SRAM1K_TAG_00 14'h0037
`define MMD_SRAM1K_TAG_01 14'h0008
`define MMD_SRAM1K_TAG_10 14'h3FF7
`define MMD_SRAM8K_TAG_00 11'h007
`define MMD_SRAM8K_TAG_01 11'h000
`define MMD_SRAM8K_TAG_10 11'h7FF
`define MMD_LOW64K_TAG 8'h00

`endif

/* inc/mmd_pkg.sv */
// Types shared by the memory map decoder.
// Assumes mmd_regs.svh supplies the numeric constants.
package mmd_pkg;

    typedef enum logic [1:0] {
        MMD_MAP_TOP_64K,
        MMD_MAP_BOTTOM,
        MMD_MAP_TOP_16M,
        MMD_MAP_RESERVED
    } mmd_map_t;

    typedef enum {
        MMD_ST_IDLE,
        MMD_ST_INT,
        MMD_ST_ADDR,
        MMD_ST_DATA
    } mmd_state_t;

endpackage : mmd_pkg

/* rtl/mmd_decoder.sv */
// Memory map decoder: APB control registers, internal region decode and the external memory bus.
// Assumes the CPU holds cpu_req with its address until cpu_ack, and pins are asynchronous to pclk.
`timescale 1ns/10ps
`default_nettype none
`include "mmd_regs.svh"

module mmd_decoder #(
    parameter bit HAS_64K_RAM = 1'b0
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic por_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic cpu_req,
    input wire logic cpu_prog,
    input wire logic cpu_write,
    input wire logic [23:0] cpu_addr,
    input wire logic [7:0] cpu_wdata,
    output logic cpu_ack,
    output logic [7:0] cpu_rdata,
    output logic rom_lo_sel,
    output logic rom_hi_sel,
    output logic sram1k_sel,
    output logic sram8k_sel,
    output logic can_ram_sel,
    output logic ram64k_sel,
    output logic stack_in_sram,
    output logic boot_internal,
    input wire logic external_access_pin,
    input wire logic bus_demux_select,
    input wire logic [7:0] p0_in,
    output logic [7:0] p0_out,
    output logic p0_oe,
    output logic [7:0] p2_out,
    output logic [7:0] p4_out,
    output logic [7:0] p5_out,
    output logic [7:0] p6_out,
    output logic [7:0] p7_out,
    output logic ale,
    output logic psen_n,
    output logic rd_n,
    output logic wr_n
);
    import mmd_pkg::*;

    logic [7:0] address_control;
    logic [7:0] memory_control;
    logic internal_ram_disable;
    logic program_ram_select;
    logic rom_bypass;
    logic [1:0] ea_sync;
    logic [1:0] demux_sync;
    logic [7:0] p0_meta;
    logic [7:0] p0_sync;
    mmd_state_t state;
    logic [23:0] addr_q;
    logic prog_q;
    logic write_q;
    logic [7:0] wdata_q;
    logic demux_q;
    logic [7:0] next_ce_n;
    logic [3:0] next_pce_n;
    logic next_rom_lo;
    logic next_rom_hi;
    logic next_s1k;
    logic next_s8k;
    logic next_can;
    logic next_r64;
    logic next_internal;
    logic rom_remap;
    logic stack_ext_mode;
    logic can_ram_remap;
    mmd_map_t data_map_select;
    logic apb_setup;
    logic apb_write;
    logic [31:0] next_prdata;
    logic next_slverr;

    assign rom_remap = address_control[`MMD_ADDRESS_CONTROL_ROM_REMAP_BIT];
    assign stack_ext_mode = address_control[`MMD_ADDRESS_CONTROL_STACK_EXT_BIT];
    assign can_ram_remap = memory_control[`MMD_MEMORY_CONTROL_CAN_REMAP_BIT];
    assign data_map_select = mmd_map_t'(memory_control[`MMD_MEMORY_CONTROL_DMS_LSB +: 2]);
    assign apb_setup = psel && !penable;
    assign apb_write = psel && penable && pwrite && pready;

    // Pin synchronisers; only the second stage is ever read
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ea_sync <= 2'h0;
            demux_sync <= 2'h0;
            p0_meta <= 8'h00;
            p0_sync <= 8'h00;
        end else begin
            ea_sync <= {ea_sync[0], external_access_pin};
            demux_sync <= {demux_sync[0], bus_demux_select};
            p0_meta <= p0_in;
            p0_sync <= p0_meta;
        end
    end

    // Registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            address_control <= `MMD_ADDRESS_CONTROL_RESET;
            memory_control <= `MMD_MEMORY_CONTROL_RESET;
            internal_ram_disable <= `MMD_MCONX_RESET;
            program_ram_select <= `MMD_MCONX_RESET;
        end else if (apb_write && pstrb[0]) begin
            if (paddr == `MMD_ADDR_ADDR_CTRL) begin
                address_control <= pwdata[7:0];
            end
            if (paddr == `MMD_ADDR_MEM_CTRL) begin
                memory_control <= pwdata[7:0];
            end
            if (paddr == `MMD_ADDR_MEM_CTRL_EXT) begin
                internal_ram_disable <= pwdata[`MMD_MCONX_IRAM_DIS_BIT];
                program_ram_select <= pwdata[`MMD_MCONX_PRAM_SEL_BIT];
            end
        end
    end

    // Only power-on reset clears the bypass bit; presetn leaves it alone
    always_ff @(posedge pclk or negedge por_n) begin
        if (!por_n) begin
            rom_bypass <= `MMD_MCONX_RESET;
        end else if (apb_write && pstrb[0] && paddr == `MMD_ADDR_MEM_CTRL_EXT) begin
            rom_bypass <= pwdata[`MMD_MCONX_ROM_BYPASS_BIT];
        end
    end

    // Read data prepared in setup so it can come from a flop in the access phase
    always_comb begin
        next_prdata = 32'h0000_0000;
        next_slverr = 1'b0;
        unique case (paddr)
            `MMD_ADDR_ADDR_CTRL: next_prdata[7:0] = address_control;
            `MMD_ADDR_MEM_CTRL: next_prdata[7:0] = memory_control;
            `MMD_ADDR_MEM_CTRL_EXT: begin
                next_prdata[`MMD_MCONX_IRAM_DIS_BIT] = internal_ram_disable;
                next_prdata[`MMD_MCONX_PRAM_SEL_BIT] = program_ram_select;
                next_prdata[`MMD_MCONX_ROM_BYPASS_BIT] = rom_bypass;
            end
            `MMD_ADDR_STATUS: begin
                next_prdata[0] = ea_sync[1];
                next_prdata[1] = demux_sync[1];
                next_prdata[2] = boot_internal;
                next_prdata[3] = stack_in_sram;
                next_prdata[4] = (state != MMD_ST_IDLE);
            end
            default: next_slverr = 1'b1;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
            pready <= 1'b0;
        end else begin
            pready <= 1'b1;
            if (apb_setup) begin
                prdata <= pwrite ? 32'h0000_0000 : next_prdata;
                pslverr <= next_slverr;
            end
        end
    end

    // Mode status outputs
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stack_in_sram <= 1'b0;
            boot_internal <= 1'b0;
        end else begin
            stack_in_sram <= stack_ext_mode;
            boot_internal <= ea_sync[1] && !rom_bypass;
        end
    end

    // Region decode of the incoming request
    always_comb begin
        next_rom_lo = 1'b0;
        next_rom_hi = 1'b0;
        next_s1k = 1'b0;
        next_s8k = 1'b0;
        next_can = 1'b0;
        next_r64 = 1'b0;
        if (cpu_prog) begin
            next_rom_hi = (cpu_addr[23:15] == `MMD_ROM_HI_TAG);
            if (ea_sync[1] && !rom_bypass) begin
                next_rom_lo = rom_remap ? (cpu_addr[23:15] == `MMD_ROM_LO_TAG_HIGH) :
                                          (cpu_addr[23:15] == `MMD_ROM_LO_TAG_LOW);
            end
            // ROM wins over program RAM where both could claim address zero
            next_r64 = HAS_64K_RAM && !internal_ram_disable && program_ram_select && !next_rom_lo &&
                       (cpu_addr[23:16] == `MMD_LOW64K_TAG);
        end else if (HAS_64K_RAM) begin
            next_can = (cpu_addr[23:8] == `MMD_CAN_TAG_HIGH);
            next_s1k = (cpu_addr[23:10] == `MMD_SRAM1K_TAG_10);
            next_r64 = !internal_ram_disable && !program_ram_select &&
                       (cpu_addr[23:16] == `MMD_LOW64K_TAG);
        end else begin
            next_can = (cpu_addr[23:8] == (can_ram_remap ? `MMD_CAN_TAG_HIGH : `MMD_CAN_TAG_LOW));
            unique case (data_map_select)
                MMD_MAP_TOP_64K: begin
                    next_s1k = (cpu_addr[23:10] == `MMD_SRAM1K_TAG_00);
                    next_s8k = (cpu_addr[23:13] == `MMD_SRAM8K_TAG_00);
                end
                MMD_MAP_BOTTOM: begin
                    next_s1k = (cpu_addr[23:10] == `MMD_SRAM1K_TAG_01);
                    next_s8k = (cpu_addr[23:13] == `MMD_SRAM8K_TAG_01);
                end
                MMD_MAP_TOP_16M: begin
                    next_s1k = (cpu_addr[23:10] == `MMD_SRAM1K_TAG_10);
                    next_s8k = (cpu_addr[23:13] == `MMD_SRAM8K_TAG_10);
                end
                MMD_MAP_RESERVED: begin
                    next_s1k = 1'b0;
                    next_s8k = 1'b0;
                end
            endcase
        end
        next_internal = next_rom_lo || next_rom_hi || next_s1k || next_s8k || next_can || next_r64;
    end

    // Chip enables: 4MB per program enable, 1MB per peripheral enable
    always_comb begin
        next_ce_n = 8'hFF;
        next_pce_n = 4'hF;
        if (prog_q) begin
            next_ce_n[addr_q[23:22]] = 1'b0;
        end else begin
            next_pce_n[addr_q[21:20]] = 1'b0;
        end
    end

    // Request sequencer
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= MMD_ST_IDLE;
            addr_q <= 24'h000000;
            prog_q <= 1'b0;
            write_q <= 1'b0;
            wdata_q <= 8'h00;
            demux_q <= 1'b0;
            cpu_ack <= 1'b0;
        end else begin
            cpu_ack <= 1'b0;
            unique case (state)
                MMD_ST_IDLE: begin
                    if (cpu_req) begin
                        addr_q <= cpu_addr;
                        prog_q <= cpu_prog;
                        write_q <= cpu_write && !cpu_prog;
                        wdata_q <= cpu_wdata;
                        demux_q <= demux_sync[1];
                        state <= next_internal ? MMD_ST_INT : MMD_ST_ADDR;
                    end
                end
                MMD_ST_INT: begin
                    cpu_ack <= 1'b1;
                    state <= MMD_ST_IDLE;
                end
                MMD_ST_ADDR: state <= MMD_ST_DATA;
                MMD_ST_DATA: begin
                    cpu_ack <= 1'b1;
                    state <= MMD_ST_IDLE;
                end
            endcase
        end
    end

    // Internal region selects held through the internal cycle and the ack cycle after it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rom_lo_sel <= 1'b0;
            rom_hi_sel <= 1'b0;
            sram1k_sel <= 1'b0;
            sram8k_sel <= 1'b0;
            can_ram_sel <= 1'b0;
            ram64k_sel <= 1'b0;
        end else if (state == MMD_ST_IDLE && cpu_req) begin
            rom_lo_sel <= next_rom_lo;
            rom_hi_sel <= next_rom_hi;
            sram1k_sel <= next_s1k;
            sram8k_sel <= next_s8k;
            can_ram_sel <= next_can;
            ram64k_sel <= next_r64;
        end else if (state != MMD_ST_INT) begin
            rom_lo_sel <= 1'b0;
            rom_hi_sel <= 1'b0;
            sram1k_sel <= 1'b0;
            sram8k_sel <= 1'b0;
            can_ram_sel <= 1'b0;
            ram64k_sel <= 1'b0;
        end
    end

    // External pins; idle and internal cycles leave the bus quiet
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            p0_out <= 8'h00;
            p0_oe <= 1'b0;
            p2_out <= 8'h00;
            p4_out <= 8'hFF;
            p5_out <= 8'hFF;
            p6_out <= 8'hFF;
            p7_out <= 8'h00;
            ale <= 1'b0;
            psen_n <= 1'b1;
            rd_n <= 1'b1;
            wr_n <= 1'b1;
            cpu_rdata <= 8'h00;
        end else begin
            unique case (state)
                MMD_ST_ADDR: begin
                    p2_out <= addr_q[15:8];
                    p6_out <= {2'b11, addr_q[21:20], next_ce_n[7:4]};
                    p4_out <= {addr_q[19:16], next_ce_n[3:0]};
                    p5_out <= {next_pce_n, 4'hF};
                    if (demux_q) begin
                        p7_out <= addr_q[7:0];
                        p0_out <= wdata_q;
                        p0_oe <= write_q;
                        ale <= 1'b0;
                    end else begin
                        p0_out <= addr_q[7:0];
                        p0_oe <= 1'b1;
                        ale <= 1'b1;
                    end
                end
                MMD_ST_DATA: begin
                    ale <= 1'b0;
                    // Mux data phase: low byte must already be latched outside
                    p0_out <= wdata_q;
                    p0_oe <= write_q;
                    psen_n <= !prog_q;
                    rd_n <= prog_q || write_q;
                    wr_n <= !write_q;
                    // Synchronised port 0 lags two cycles; slow devices must hold data
                    cpu_rdata <= p0_sync;
                end
                default: begin
                    p0_oe <= 1'b0;
                    ale <= 1'b0;
                    psen_n <= 1'b1;
                    rd_n <= 1'b1;
                    wr_n <= 1'b1;
                    p4_out <= 8'hFF;
                    p5_out <= 8'hFF;
                    p6_out <= 8'hFF;
                end
            endcase
        end
    end

endmodule : mmd_decoder
`default_nettype wire

/* sim/mmd_decoder_props.sv */
// Concurrent checks on the memory map decoder's CPU side and external bus pins.
// Assumes the CPU holds cpu_addr, cpu_prog and cpu_wdata until cpu_ack.
`timescale 1ns/10ps
`default_nettype none

module mmd_decoder_props #(
    parameter bit HAS_64K_RAM = 1'b0
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic cpu_prog,
    input wire logic [23:0] cpu_addr,
    input wire logic [7:0] cpu_wdata,
    input wire logic cpu_ack,
    input wire logic rom_lo_sel,
    input wire logic rom_hi_sel,
    input wire logic sram1k_sel,
    input wire logic sram8k_sel,
    input wire logic can_ram_sel,
    input wire logic ram64k_sel,
    input wire logic [7:0] p0_out,
    input wire logic p0_oe,
    input wire logic [7:0] p2_out,
    input wire logic [7:0] p4_out,
    input wire logic [7:0] p5_out,
    input wire logic [7:0] p6_out,
    input wire logic ale,
    input wire logic psen_n,
    input wire logic rd_n,
    input wire logic wr_n
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    logic int_hit;
    logic strobe;
    assign int_hit = rom_lo_sel | rom_hi_sel | sram1k_sel | sram8k_sel | can_ram_sel | ram64k_sel;
    assign strobe = !(psen_n && rd_n && wr_n);

    chk_int_quiet: assert property (int_hit |-> !strobe && !ale && p4_out[3:0] == 4'hF &&
        p6_out[3:0] == 4'hF && p5_out[7:4] == 4'hF) else $error("internal hit not quiet");
    // Selects stay up through the ack cycle, so the ack follows the first select cycle
    chk_int_ack: assert property (int_hit && !cpu_ack |=> cpu_ack && int_hit)
        else $error("internal hit not acknowledged");
    chk_sel_onehot: assert property ($onehot0({rom_lo_sel, rom_hi_sel, sram1k_sel, sram8k_sel,
        can_ram_sel, ram64k_sel})) else $error("two regions selected");
    chk_rom_hi_addr: assert property (rom_hi_sel |-> cpu_prog && cpu_addr[23:15] == 9'h1FF)
        else $error("upper rom outside its range");
    chk_rom_lo_addr: assert property (rom_lo_sel |-> cpu_prog &&
        (cpu_addr[23:15] == 9'h000 || cpu_addr[23:15] == 9'h1FE)) else $error("lower rom outside its range");
    chk_can_addr: assert property (can_ram_sel |-> !cpu_prog &&
        (cpu_addr[23:8] == 16'h00DB || cpu_addr[23:8] == 16'hFFDB)) else $error("can ram outside its range");
    chk_no_big_ram: assert property (!HAS_64K_RAM |-> !ram64k_sel) else $error("64k ram in small variant");
    chk_addr_phase: assert property (ale |-> p2_out == cpu_addr[15:8] && p4_out[7:4] == cpu_addr[19:16] &&
        p6_out[5:4] == cpu_addr[21:20] ##1 !ale && strobe) else $error("address phase wrong");
    chk_strobe_end: assert property (strobe |-> cpu_ack ##1 !strobe && !p0_oe)
        else $error("strobe not closed by ack");
    chk_ce_index: assert property (!psen_n |-> rd_n && wr_n && p4_out[3:0] == ~(4'h1 << cpu_addr[23:22]) &&
        p6_out[3:0] == 4'hF) else $error("chip enable wrong");
    chk_pce_index: assert property ((!rd_n || !wr_n) |-> !cpu_prog && p4_out[3:0] == 4'hF &&
        p5_out[7:4] == ~(4'h1 << cpu_addr[21:20])) else $error("peripheral enable wrong");
    chk_write_data: assert property (!wr_n |-> p0_oe && p0_out == cpu_wdata) else $error("write data wrong");
    chk_read_float: assert property ((!rd_n || !psen_n) |-> !p0_oe) else $error("port 0 driven on read");

    cov_int: cover property (int_hit ##1 cpu_ack);
    cov_fetch: cover property (ale ##1 !psen_n);
    cov_read: cover property (!rd_n);
    cov_write: cover property (!wr_n);
endmodule : mmd_decoder_props

bind mmd_decoder mmd_decoder_props #(.HAS_64K_RAM(HAS_64K_RAM)) u_mmd_decoder_props (
    .pclk(pclk), .presetn(presetn), .cpu_prog(cpu_prog), .cpu_addr(cpu_addr), .cpu_wdata(cpu_wdata),
    .cpu_ack(cpu_ack), .rom_lo_sel(rom_lo_sel), .rom_hi_sel(rom_hi_sel), .sram1k_sel(sram1k_sel),
    .sram8k_sel(sram8k_sel), .can_ram_sel(can_ram_sel), .ram64k_sel(ram64k_sel), .p0_out(p0_out),
    .p0_oe(p0_oe), .p2_out(p2_out), .p4_out(p4_out), .p5_out(p5_out), .p6_out(p6_out), .ale(ale),
    .psen_n(psen_n), .rd_n(rd_n), .wr_n(wr_n));

`default_nettype wire

/* sim/mmd_mem_model.sv */
// External memory on the far side of the decoder's bus pins.
// Assumes pins change just after pclk edges; answers on the pclk edge that ends the strobe cycle.
`timescale 1ns/10ps
`default_nettype none

module mmd_mem_model (
    input wire logic pclk,
    input wire logic [7:0] p0_out,
    input wire logic [7:0] p7_out,
    input wire logic ale,
    input wire logic psen_n,
    input wire logic rd_n,
    input wire logic bus_demux_select,
    output logic [7:0] p0_in
);
    logic [7:0] low_addr = 8'h00;
    initial p0_in = 8'h5A;
    // Latch on pclk, not on ale fall: port 0 turns to data at that same edge
    always @(posedge pclk) begin
        if (ale) begin
            low_addr <= p0_out;
        end
    end
    // Released bus toggles every cycle so a stale value never looks valid
    always @(posedge pclk) begin
        if (!psen_n || !rd_n) begin
            p0_in <= ~(bus_demux_select ? p7_out : low_addr);
        end else begin
            p0_in <= ~p0_in;
        end
    end
endmodule : mmd_mem_model

`default_nettype wire

/* sim/tb_top.sv */
// Self-checking bench for the memory map decoder: APB set-up, CPU accesses, external bus.
// Assumes mmd_regs.svh on the include path and the small variant of the decoder.
`timescale 1ns/10ps
`default_nettype none
`include "mmd_regs.svh"

module tb_top;
    logic pclk = 1'b0;
    logic presetn, por_n, psel, penable, pwrite, pready, pslverr, cpu_req, cpu_prog, cpu_write, cpu_ack;
    logic rom_lo_sel, rom_hi_sel, sram1k_sel, sram8k_sel, can_ram_sel, ram64k_sel, stack_in_sram;
    logic boot_internal, external_access_pin, bus_demux_select, p0_oe, ale, psen_n, rd_n, wr_n, errv, ext;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rdv;
    logic [3:0] pstrb, ce;
    logic [23:0] cpu_addr;
    logic [7:0] cpu_wdata, cpu_rdata, p0_in, p0_out, p2_out, p4_out, p5_out, p6_out, p7_out, lo;
    logic [5:0] sel;
    int bad_count = 0;
    int comparisons = 0;

    mmd_decoder #(.HAS_64K_RAM(1'b0)) u_mmd_decoder (.*);
    mmd_mem_model u_mmd_mem_model (.pclk(pclk), .p0_out(p0_out), .p7_out(p7_out), .ale(ale), .psen_n(psen_n),
        .rd_n(rd_n), .bus_demux_select(bus_demux_select), .p0_in(p0_in));

    always #2 pclk = ~pclk;

    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
        comparisons++;
        if (seen !== exp) begin
            bad_count++;
            $display("CHECK FAILED t=%0t %s: seen %h expected %h", $time, msg, seen, exp);
        end
    endtask : check

    task automatic finish_test;
        $display("comparisons=%0d bad_count=%0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : finish_test

    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rdv = prdata;
        errv = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        check(n < 20, 1, "apb answer");
    endtask : apb

    // Ack edge is known from the hand-over, so request drops in the ack cycle
    task automatic cpu(input logic prog, input logic wr, input logic [23:0] a, input int lat);
        int i;
        logic ackd;
        sel = 6'h00;
        ce = 4'hF;
        ext = 1'b0;
        lo = 8'h00;
        ackd = 1'b0;
        @(posedge pclk);
        cpu_req <= 1'b1;
        cpu_prog <= prog;
        cpu_write <= wr;
        cpu_addr <= a;
        cpu_wdata <= a[7:0] ^ 8'h3C;
        for (i = 1; i <= 8 && !ackd; i++) begin
            @(posedge pclk);
            if (i == lat) cpu_req <= 1'b0;
            #1;
            sel |= {rom_lo_sel, rom_hi_sel, sram1k_sel, sram8k_sel, can_ram_sel, ram64k_sel};
            if (ale === 1'b1) lo = p0_out;
            if (!(psen_n && rd_n && wr_n)) begin
                ext = 1'b1;
                ce = p4_out[3:0];
                if (bus_demux_select) lo = p7_out;
            end
            if (cpu_ack === 1'b1) begin
                ackd = 1'b1;
                check(i, lat, "ack latency");
            end
        end
        check(ackd, 1, "ack seen");
    endtask : cpu

    task automatic rst(input logic por);
        @(posedge pclk);
        presetn <= 1'b0;
        por_n <= !por;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        por_n <= 1'b1;
        repeat (3) @(posedge pclk);
    endtask : rst

    task automatic t_regs;
        apb(0, `MMD_ADDR_ADDR_CTRL, 0);
        check(rdv, {24'h0, `MMD_ADDRESS_CONTROL_RESET}, "address_control reset");
        apb(0, `MMD_ADDR_MEM_CTRL, 0);
        check(rdv, {24'h0, `MMD_MEMORY_CONTROL_RESET}, "memory_control reset");
        apb(0, `MMD_ADDR_STATUS, 0);
        check(rdv, 32'h5, "status reset");
        apb(0, 12'h000, 0);
        check({rdv[30:0], errv}, 32'h1, "unmapped read");
    endtask : t_regs

    task automatic t_rom;
        cpu(1, 0, 24'hFF8000, 2);
        check(sel, 6'h10, "upper rom");
        cpu(1, 0, 24'h007FFF, 2);
        check(sel, 6'h20, "lower rom low");
        apb(1, `MMD_ADDR_ADDR_CTRL, 32'h20);
        cpu(1, 0, 24'hFF7FFF, 2);
        check(sel, 6'h20, "lower rom high");
        cpu(1, 0, 24'h000000, 3);
        check({sel, ext, ce}, {6'h00, 1'b1, 4'hE}, "fetch at zero goes out");
        apb(1, `MMD_ADDR_ADDR_CTRL, 32'h00);
    endtask : t_rom

    task automatic t_bypass;
        apb(1, `MMD_ADDR_MEM_CTRL_EXT, 32'h1);
        repeat (2) @(posedge pclk);
        check(boot_internal, 1'b0, "bypass skips firmware");
        rst(1'b0);
        apb(0, `MMD_ADDR_MEM_CTRL_EXT, 0);
        check(rdv, 32'h1, "bypass kept by reset");
    endtask : t_bypass

    task automatic t_ea;
        external_access_pin <= 1'b0;
        rst(1'b0);
        cpu(1, 0, 24'h000000, 3);
        check({sel, ext, ce}, {6'h00, 1'b1, 4'hE}, "pin low hides rom");
        apb(0, `MMD_ADDR_STATUS, 0);
        check(rdv, 32'h0, "status pin low");
        external_access_pin <= 1'b1;
        rst(1'b1);
        apb(0, `MMD_ADDR_MEM_CTRL_EXT, 0);
        check(rdv, 32'h0, "bypass cleared by power-on");
        check(boot_internal, 1'b1, "firmware runs");
    endtask : t_ea

    task automatic t_map;
        logic [23:0] b1k [3] = '{24'h00DC00, 24'h002000, 24'hFFDC00};
        logic [23:0] b8k [3] = '{24'h00E000, 24'h000000, 24'hFFE000};
        for (int m = 0; m < 3; m++) begin
            for (int c = 0; c < 2; c++) begin
                apb(1, `MMD_ADDR_MEM_CTRL, (m << 6) | (c << 3));
                cpu(0, 0, b1k[m] + 24'h0003FF, 2);
                check(sel, 6'h08, "1k block");
                cpu(0, 1, b8k[m] + 24'h001FFF, 2);
                check(sel, 6'h04, "8k block");
                cpu(0, 0, c ? 24'hFFDBFF : 24'h00DB00, 2);
                check(sel, 6'h02, "can block");
            end
        end
        apb(1, `MMD_ADDR_MEM_CTRL, 32'hC0);
        cpu(0, 0, 24'h00E000, 3);
        check({sel, ext}, {6'h00, 1'b1}, "no block mapped");
        apb(1, `MMD_ADDR_MEM_CTRL, 32'h00);
    endtask : t_map

    task automatic t_stack;
        apb(1, `MMD_ADDR_ADDR_CTRL, 32'h04);
        repeat (2) @(posedge pclk);
        check(stack_in_sram, 1'b1, "stack mode on");
        apb(1, `MMD_ADDR_ADDR_CTRL, 32'h00);
        repeat (2) @(posedge pclk);
        check(stack_in_sram, 1'b0, "stack mode off");
    endtask : t_stack

    task automatic t_ext;
        for (int dm = 0; dm < 2; dm++) begin
            bus_demux_select <= dm[0];
            repeat (4) @(posedge pclk);
            cpu(0, 0, 24'h6A5C3E, 3);
            check({ext, lo}, {1'b1, 8'h3E}, "low address byte");
            cpu(0, 1, 24'h312345, 3);
            check(ext, 1'b1, "data write");
            cpu(1, 0, 24'hC01234, 3);
            check({ext, ce}, {1'b1, 4'h7}, "chip enable 3");
        end
    endtask : t_ext

    initial begin
        #100000;
        bad_count++;
        finish_test();
    end

    initial begin
        {presetn, por_n, psel, penable, pwrite, cpu_req, cpu_prog, cpu_write, bus_demux_select} = 9'h000;
        paddr = 12'h000;
        pwdata = 32'h0;
        pstrb = 4'hF;
        cpu_addr = 24'h000000;
        cpu_wdata = 8'h00;
        external_access_pin = 1'b1;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        por_n <= 1'b1;
        repeat (3) @(posedge pclk);
        t_regs();
        t_rom();
        t_bypass();
        t_ea();
        t_map();
        t_stack();
        t_ext();
        finish_test();
    end
endmodule : tb_top

`default_nettype wire
